// ===== hdl/twr_params.svh
// Purpose: constants of the write-reverse data-control sequencer
// Assumes: core clock of 40 MHz
// Notes:   control flops reset to zero, except state, which resets to TWR_IDLE (4'h1)
`ifndef TWR_PARAMS_SVH
`define TWR_PARAMS_SVH
`define TWR_CLK_PERIOD_NS  25
`define TWR_STEP_DELAY_NS  1000
`define TWR_STEP_CYCLES    ((`TWR_STEP_DELAY_NS + `TWR_CLK_PERIOD_NS - 1) / `TWR_CLK_PERIOD_NS)
`define TWR_WORD_W         36
`define TWR_HALF_W         18
`define TWR_CHAR_W         6
`define TWR_LAST_STROBE    2'h2
`define TWR_STEP_CNT_W     6
`endif

// ===== hdl/twr_pkg.sv
// Purpose: types shared by the write-reverse sequencer
// Assumes: nothing
// Notes:   step numbers 1..6 name the internal timing pulses
package twr_pkg;
  typedef enum logic [3:0] {
    TWR_IDLE        = 4'h1,
    TWR_DELAY       = 4'h2,
    TWR_WAIT_WORD   = 4'h4,
    TWR_WAIT_STROBE = 4'h8
  } twr_state_t;

  typedef logic [2:0] twr_step_t;

  // step number to one-hot timing pulse lane
  function automatic logic [5:0] twr_step_onehot(input twr_step_t s);
    case (s)
      3'h1:    twr_step_onehot = 6'h01;
      3'h2:    twr_step_onehot = 6'h02;
      3'h3:    twr_step_onehot = 6'h04;
      3'h4:    twr_step_onehot = 6'h08;
      3'h5:    twr_step_onehot = 6'h10;
      3'h6:    twr_step_onehot = 6'h20;
      default: twr_step_onehot = 6'h00;
    endcase
  endfunction
endpackage

// ===== hdl/twr_sequencer.sv
// Purpose: write-reverse data-control sequencer of a tape controller
// Assumes: all inputs synchronous to core_clk_i; strobes are one-cycle pulses
// Notes:   bit 0 of a word is its lowest order bit
`timescale 1ns/1ps
`default_nettype none
`include "twr_params.svh"

// Contract
// - control load starts sequencing and runs timing pulses three to six.
// - reverse writing puts the lowest three bits of each character out first.
// - shift register reorders buffer so the low 18-bit half is written first.
// - pulses four to six load low half; pulses one, two present lowest six bits.
// - first and second tape strobes each shift the next six bits to the buffer.
// - third strobe runs pulses one to six: clear, load high half, request word.
// - after pulse six, pulses one, two present the high half's low six bits.
// - last strobe of a word readies registers; new word repeats the sequence.
// - overrun flag set when tape needs data not yet delivered; transfer halts.
// - data load fills both buffer halves and clears the word request.
// - pulse five moves second half to first, shift register to second, clears.
// - half swap repeats pulse four; it toggles at counter zero in reverse.
module twr_sequencer (
  input  wire logic                       core_clk_i,           // core clock
  input  wire logic                       reset_i,              // async reset, high
  input  wire logic                       control_load_pulse_i, // start command
  input  wire logic                       data_load_pulse_i,    // host word strobe
  input  wire logic [`TWR_WORD_W-1:0]     data_word_i,          // host data word
  input  wire logic                       tape_strobe_i,        // per-character strobe
  input  wire logic                       reverse_motion_cmd_i, // reverse direction
  output logic      [`TWR_CHAR_W-1:0]     read_write_buffer_o,  // character to tape
  output logic                            char_ready_o,         // new character pulse
  output logic      [5:0]                 seq_timing_pulse_o,   // pulses one..six
  output logic                            word_request_flag_o,  // word wanted
  output logic                            word_pending_flag_o,  // word awaited
  output logic                            data_overrun_flag_o,  // data missed
  output logic                            half_swap_flag_o,     // swap in progress
  output logic                            write_setup_flag_o,   // positioning pass
  output logic                            half_counter_o,       // half in progress
  output logic                            busy_o                // sequencer active
);
  import twr_pkg::*;

  localparam int STEP_CYC = `TWR_STEP_CYCLES;
  localparam int STEP_P1  = `TWR_STEP_CYCLES + 1;
  localparam int STEP_X3  = 3 * `TWR_STEP_CYCLES + 1;
  localparam logic [`TWR_STEP_CNT_W-1:0] DLY_LOAD = `TWR_STEP_CNT_W'(`TWR_STEP_CYCLES - 1);

  twr_state_t                  state;
  twr_step_t                   step;
  logic [`TWR_STEP_CNT_W-1:0]  dly;
  logic [1:0]                  strb_cnt;
  logic                        full_seq;
  logic                        first_word;
  logic [`TWR_HALF_W-1:0]      buf_first;
  logic [`TWR_HALF_W-1:0]      buf_second;
  logic [`TWR_HALF_W-1:0]      char_shift_reg;
  logic [5:0]                  fire;
  logic                        strobe_taken;
  logic                        overrun_hit;
  logic                        word_taken;

  // a pulse fires when the step delay has run out
  assign fire         = (state == TWR_DELAY && dly == '0) ? twr_step_onehot(step) : 6'h00;
  assign strobe_taken = tape_strobe_i && state == TWR_WAIT_STROBE;
  assign overrun_hit  = tape_strobe_i && state == TWR_WAIT_WORD && !first_word;
  assign word_taken   = data_load_pulse_i && word_request_flag_o;
  assign busy_o       = (state != TWR_IDLE);

  // step sequencer; a restart command overrides whatever is in flight
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= TWR_IDLE;
      step  <= 3'h0;
      dly   <= '0;
    end else if (control_load_pulse_i) begin
      state <= TWR_DELAY;
      step  <= 3'h3;
      dly   <= DLY_LOAD;
    end else begin
      case (state)
        TWR_DELAY: begin
          if (dly != '0) begin
            dly <= dly - 1'b1;
          end else begin
            dly <= DLY_LOAD;
            case (step)
              3'h1: step <= 3'h2;
              3'h2: begin
                if (full_seq) step <= 3'h3;
                else state <= TWR_WAIT_STROBE;
              end
              3'h3: begin
                if (!half_counter_o) state <= TWR_WAIT_WORD;
                else step <= 3'h4;
              end
              3'h4: step <= 3'h5;
              3'h5: step <= half_swap_flag_o ? 3'h4 : 3'h6;
              3'h6: begin
                if (write_setup_flag_o) step <= 3'h1;
                else state <= TWR_WAIT_STROBE;
              end
              default: state <= TWR_IDLE;
            endcase
          end
        end
        TWR_WAIT_WORD: begin
          if (overrun_hit) begin
            state <= TWR_IDLE;
          end else if (word_pending_flag_o && !word_request_flag_o) begin
            state <= TWR_DELAY;
            step  <= 3'h4;
            dly   <= DLY_LOAD;
          end
        end
        TWR_WAIT_STROBE: begin
          if (tape_strobe_i) begin
            state <= TWR_DELAY;
            step  <= 3'h1;
            dly   <= DLY_LOAD;
          end
        end
        TWR_IDLE: state <= TWR_IDLE;
        default:  state <= TWR_IDLE;
      endcase
    end
  end

  // strobe counting: the third strobe of a half runs the full pulse chain
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      strb_cnt <= 2'h0;
      full_seq <= 1'b0;
    end else if (control_load_pulse_i) begin
      strb_cnt <= 2'h0;
      full_seq <= 1'b0;
    end else if (strobe_taken) begin
      if (strb_cnt == `TWR_LAST_STROBE) begin
        strb_cnt <= 2'h0;
        full_seq <= 1'b1;
      end else begin
        strb_cnt <= strb_cnt + 2'h1;
      end
    end else if (fire[2]) begin
      full_seq <= 1'b0;
    end
  end

  // character shift register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      char_shift_reg <= '0;
    end else if (fire[2]) begin
      char_shift_reg <= '0;
    end else if (fire[3]) begin
      char_shift_reg <= buf_first;
    end else if (fire[4] && half_swap_flag_o) begin
      char_shift_reg <= '0;
    end else if (fire[0] && !write_setup_flag_o && !full_seq) begin
      char_shift_reg <= {6'h00, char_shift_reg[`TWR_HALF_W-1:`TWR_CHAR_W]};
    end
  end

  // two-half buffer; the host may refill it only while a word is requested
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      buf_first  <= '0;
      buf_second <= '0;
    end else if (word_taken) begin
      buf_first  <= data_word_i[`TWR_WORD_W-1:`TWR_HALF_W];
      buf_second <= data_word_i[`TWR_HALF_W-1:0];
    end else if (fire[4]) begin
      buf_first  <= buf_second;
      buf_second <= char_shift_reg;
    end
  end

  // word request and pending flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_request_flag_o <= 1'b0;
      word_pending_flag_o <= 1'b0;
    end else begin
      if (control_load_pulse_i || (fire[5] && half_counter_o)) word_request_flag_o <= 1'b1;
      else if (word_taken) word_request_flag_o <= 1'b0;
      if (fire[2] && !half_counter_o) word_pending_flag_o <= 1'b1;
      else if (fire[4] || control_load_pulse_i) word_pending_flag_o <= 1'b0;
    end
  end

  // swap, setup and half counter flags
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      half_swap_flag_o   <= 1'b0;
      write_setup_flag_o <= 1'b0;
      half_counter_o     <= 1'b0;
    end else if (control_load_pulse_i) begin
      half_swap_flag_o   <= 1'b0;
      write_setup_flag_o <= 1'b0;
      half_counter_o     <= 1'b0;
    end else begin
      if (fire[3] && reverse_motion_cmd_i && !half_counter_o)
        half_swap_flag_o <= !half_swap_flag_o;
      if (fire[3] && reverse_motion_cmd_i) write_setup_flag_o <= 1'b1;
      else if (fire[1]) write_setup_flag_o <= 1'b0;
      if (fire[5]) half_counter_o <= !half_counter_o;
    end
  end

  // overrun flag; only a new control load clears it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_overrun_flag_o <= 1'b0;
      first_word          <= 1'b0;
    end else begin
      if (overrun_hit) data_overrun_flag_o <= 1'b1;
      else if (control_load_pulse_i) data_overrun_flag_o <= 1'b0;
      if (control_load_pulse_i) first_word <= 1'b1;
      else if (fire[3]) first_word <= 1'b0;
    end
  end

  // character out: the three low bits lead so they reach tape first
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      read_write_buffer_o <= '0;
      char_ready_o        <= 1'b0;
      seq_timing_pulse_o  <= 6'h00;
    end else begin
      seq_timing_pulse_o <= fire;
      char_ready_o       <= fire[1] && !full_seq;
      if (fire[1] && !full_seq)
        read_write_buffer_o <= {char_shift_reg[2:0], char_shift_reg[5:3]};
    end
  end

  // last delivered word, read only by the checks below
  logic [`TWR_WORD_W-1:0] chk_word;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) chk_word <= '0;
    else if (word_taken) chk_word <= data_word_i;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  start_chain_a: assert property (control_load_pulse_i |=> state == TWR_DELAY && step == 3'h3)
    else $error("control load did not start step three");
  char_order_a: assert property (char_ready_o |-> read_write_buffer_o ==
    {$past(char_shift_reg[2:0]), $past(char_shift_reg[5:3])})
    else $error("character bits not low three first");
  low_half_a: assert property (seq_timing_pulse_o[5] && half_counter_o
    |-> char_shift_reg == chk_word[`TWR_HALF_W-1:0])
    else $error("low half not in shift register");
  low_setup_a: assert property (seq_timing_pulse_o[5] && write_setup_flag_o && half_counter_o
    |-> ##STEP_CYC seq_timing_pulse_o[0] ##STEP_CYC (seq_timing_pulse_o[1] && char_ready_o))
    else $error("low half positioning missing");
  strobe_shift_a: assert property (strobe_taken && strb_cnt != `TWR_LAST_STROBE && !control_load_pulse_i
    |-> ##STEP_P1 seq_timing_pulse_o[0] ##STEP_CYC (seq_timing_pulse_o[1] && char_ready_o))
    else $error("strobe did not present next character");
  full_chain_a: assert property (strobe_taken && strb_cnt == `TWR_LAST_STROBE && !control_load_pulse_i
    |-> ##STEP_P1 seq_timing_pulse_o[0] ##STEP_CYC (seq_timing_pulse_o[1] && !char_ready_o)
    ##STEP_CYC seq_timing_pulse_o[2] ##1 char_shift_reg == '0)
    else $error("third strobe chain wrong");
  high_setup_a: assert property (seq_timing_pulse_o[5] && write_setup_flag_o && !half_counter_o
    |-> ##STEP_CYC seq_timing_pulse_o[0] ##STEP_CYC char_ready_o)
    else $error("high half positioning missing");
  word_end_a: assert property (strobe_taken && strb_cnt == `TWR_LAST_STROBE && !half_counter_o
    && !control_load_pulse_i |-> ##STEP_X3 word_pending_flag_o)
    else $error("word end did not await next word");
  overrun_halt_a: assert property (overrun_hit && !control_load_pulse_i
    |=> data_overrun_flag_o && state == TWR_IDLE)
    else $error("overrun not flagged or not halted");
  data_load_a: assert property (word_taken && !fire[5] && !control_load_pulse_i
    |=> !word_request_flag_o && buf_first == $past(data_word_i[`TWR_WORD_W-1:`TWR_HALF_W]))
    else $error("data load mishandled");
  half_move_a: assert property (seq_timing_pulse_o[4] |-> !word_pending_flag_o
    && buf_first == $past(buf_second) && buf_second == $past(char_shift_reg))
    else $error("pulse five transfer wrong");
  swap_repeat_a: assert property (seq_timing_pulse_o[4] && half_swap_flag_o
    |-> ##STEP_CYC seq_timing_pulse_o[3] ##1 !half_swap_flag_o)
    else $error("swap did not repeat pulse four");
  pulse_gap_a: assert property (seq_timing_pulse_o != 6'h00 && state == TWR_DELAY
    |=> (seq_timing_pulse_o == 6'h00) [*8])
    else $error("timing pulses too close");

  overrun_c: cover property (data_overrun_flag_o && !busy_o);
  swap_c:    cover property (seq_timing_pulse_o[3] && half_swap_flag_o);
  rerequest_c: cover property (seq_timing_pulse_o[5] ##1 word_request_flag_o && !first_word);
endmodule // twr_sequencer
`default_nettype wire

// ===== testbench/twr_host_model.sv
// Purpose: host data-bus model that answers word requests of the sequencer
// Assumes: one clock, sequencer flags are registers
// Notes:   latency and stray loads are commanded by the testbench
`timescale 1ns/1ps
`default_nettype none
`include "twr_params.svh"
module twr_host_model (
  input  wire logic                   clk_i,               // core clock
  input  wire logic                   reset_i,             // async reset, high
  input  wire logic                   word_request_flag_i, // device wants a word
  input  wire logic                   enable_i,            // host answers requests
  input  wire logic                   spurious_i,          // allow stray loads
  input  wire logic [5:0]             lat_i,               // answer latency, cycles
  output logic                        data_load_pulse_o,   // one-cycle word strobe
  output logic [`TWR_WORD_W-1:0]      data_word_o          // host word
);
  int cnt;
  // one word per request; a stray load with no request must be ignored
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_load_pulse_o <= 1'b0;
      data_word_o       <= '0;
      cnt               <= 0;
    end else begin
      data_load_pulse_o <= 1'b0;
      // bus released after the strobe: show no stale word
      if (data_load_pulse_o) data_word_o <= ~data_word_o;
      if (word_request_flag_i && enable_i && !data_load_pulse_o) begin
        if (cnt >= lat_i) begin
          data_load_pulse_o <= 1'b1;
          data_word_o       <= `TWR_WORD_W'({$urandom, $urandom});
          cnt               <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end else if (!word_request_flag_i && spurious_i && ($urandom % 64 == 0)) begin
        data_load_pulse_o <= 1'b1;
        data_word_o       <= `TWR_WORD_W'({$urandom, $urandom});
      end
    end
  end
endmodule // twr_host_model
`default_nettype wire

// ===== testbench/tape_write_reverse_sequencer_tb.sv
// Purpose: self-checking bench for the write-reverse sequencer
// Assumes: 40 MHz clock, reverse motion held high
// Notes:   expected characters are queued when the host word is taken
`timescale 1ns/1ps
`default_nettype none
`include "twr_params.svh"
module tape_write_reverse_sequencer_tb;
  logic core_clk_i = 0, reset_i = 1, ctl = 0, strobe = 0, rev = 1;
  logic host_en = 1, spur = 1, load;
  logic [5:0] lat = 0, read_write_buffer, tp;
  logic [`TWR_WORD_W-1:0] word;
  logic rdy, req, pend, ovr, bsy;
  logic [5:0] exp_q[$];
  int n_errors = 0, compares = 0, n_chars = 0, cyc = 0;
  bit took;
  always #12.5 core_clk_i = ~core_clk_i;
  twr_sequencer dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .control_load_pulse_i(ctl), .data_load_pulse_i(load), .data_word_i(word),
    .tape_strobe_i(strobe), .reverse_motion_cmd_i(rev), .read_write_buffer_o(read_write_buffer),
    .char_ready_o(rdy), .seq_timing_pulse_o(tp), .word_request_flag_o(req),
    .word_pending_flag_o(pend), .data_overrun_flag_o(ovr), .half_swap_flag_o(),
    .write_setup_flag_o(), .half_counter_o(), .busy_o(bsy));
  twr_host_model host (.clk_i(core_clk_i), .reset_i(reset_i), .word_request_flag_i(req),
    .enable_i(host_en), .spurious_i(spur), .lat_i(lat), .data_load_pulse_o(load),
    .data_word_o(word));
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // taken word: low half first, each char with its low three bits leading
  always @(posedge core_clk_i) begin
    if (took) chk(req === 1'b0, "request not cleared by load");
    took = load && req;
    if (took) for (int g = 0; g < 6; g++) exp_q.push_back({word[6*g+:3], word[6*g+3+:3]});
  end
  // character monitor: oldest note against each new character
  always @(posedge core_clk_i) begin
    if (!reset_i && rdy) begin
      n_chars++;
      if (exp_q.size() == 0) chk(1'b0, "character with none expected");
      else chk(read_write_buffer === exp_q.pop_front(), "character order or value");
    end
  end
  // hang guard, well above five words of traffic
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end
  task automatic pulse_strobe;
    @(posedge core_clk_i) strobe <= 1'b1;
    @(posedge core_clk_i) strobe <= 1'b0;
  endtask
  task automatic start;
    @(posedge core_clk_i) ctl <= 1'b1;
    @(posedge core_clk_i) ctl <= 1'b0;
    #1;
  endtask
  task automatic run_chars(input int n);
    int seen;
    for (int i = 0; i < n; i++) begin
      seen = n_chars;
      for (int k = 0; k < 2000 && n_chars == seen; k++) begin
        @(posedge core_clk_i);
        #1;
      end
      chk(n_chars != seen, "no character");
      lat <= 6'($urandom % 64);
      if (n == 24 && i == 18) host_en <= 1'b0;
      repeat ($urandom % 6) @(posedge core_clk_i);
      pulse_strobe();
    end
  endtask
  initial begin
    void'($urandom(58205));
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    start();
    chk(req === 1'b1, "request after control load");
    chk(bsy === 1'b1, "sequencer idle after control load");
    // pulse three is registered on the fortieth edge after the load is taken
    repeat (40) @(posedge core_clk_i);
    #1;
    chk(tp === 6'h04, "third pulse one step after start");
    run_chars(24);
    // host silent: strobes while a word is awaited must overrun
    for (int k = 0; k < 20 && ovr !== 1'b1; k++) begin
      repeat (100) @(posedge core_clk_i);
      pulse_strobe();
    end
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(ovr === 1'b1, "overrun not flagged");
    chk(bsy === 1'b0, "transfer not halted by overrun");
    chk(pend === 1'b1, "next word not awaited at overrun");
    repeat (400) @(posedge core_clk_i);
    chk(exp_q.size() == 0, "characters lost");
    // host woken only after the restart, so a stale request is not answered
    start();
    host_en <= 1'b1;
    #25;
    chk(ovr === 1'b0, "overrun not cleared by restart");
    run_chars(6);
    results();
  end
endmodule // tape_write_reverse_sequencer_tb
`default_nettype wire
